// >>> src/thp_tx_port.sv
// Transmit host port: write decode, mode mapping, 256-entry FIFO, drain.
// Assumes mode pins are static and both reset inputs are joined into reset_n.
// Host write clock and reference clock are the same clock here.

`timescale 1ns/1ps

module thp_tx_port
    import thp_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        reset_n,
    input  wire logic                        buffer_bypass_select,
    input  wire logic                        coder_bypass_select,
    input  wire logic                        char_width_select,
    input  wire logic                        cascade_timing_select,
    input  wire logic                        range_select_pin,
    input  wire logic                        speed_select_pin,
    input  wire logic                        address_match_n,
    input  wire logic                        write_select,
    input  wire logic [thp_pkg::WORD_W-1:0]  tx_parallel_word,
    input  wire logic                        special_or_data_select,
    input  wire logic                        char_ready,
    output logic                             fifo_empty_flag,
    output logic                             fifo_full_flag,
    output logic                             fifo_half_full_n,
    output logic                             char_valid,
    output logic [thp_pkg::ENTRY_W-1:0]      char_word,
    output logic [4:0]                       bit_rate_x2,
    output logic                             fifo_mode
);
    import thp_pkg::*;

    // ****************************************
    // Mode decode
    // ****************************************
    // Character modes from the two width and coder pins
    wire fifo_on   = buffer_bypass_select;
    wire enc8      = coder_bypass_select & char_width_select;
    wire raw10     = ~coder_bypass_select & char_width_select;
    wire enc10     = coder_bypass_select & ~char_width_select;
    wire raw12     = ~coder_bypass_select & ~char_width_select;

    // Bypass with encoding must be 8-bit; enc10 there is host misuse
    wire [WORD_W-1:0] word_mask =
        enc8  ? (fifo_on ? MASK_ENC8_BUF : MASK_ENC8_BYP) :
        raw10 ? MASK_RAW10 :
        enc10 ? (fifo_on ? MASK_ENC10_BUF : MASK_ENC10_BYP) :
                MASK_RAW12;

    // Special select only means something in encoded modes
    wire scd_kept = special_or_data_select & coder_bypass_select;

    // Unused positions forced to zero, bit 0 stays first on the line
    wire [ENTRY_W-1:0] mapped_entry =
        {~coder_bypass_select, scd_kept,
         tx_parallel_word & word_mask};

    // Clock multiple from range, speed, coder and width pins
    wire [4:0] rate_d =
        raw12 ? (range_select_pin ? RATE_X2_HIGH12 :
                 (speed_select_pin ? RATE_X2_MID12 : RATE_X2_LOW12)) :
                (range_select_pin ? RATE_X2_HIGH :
                 (speed_select_pin ? RATE_X2_MID : RATE_X2_LOW));

    // ****************************************
    // Write select and address decode
    // ****************************************
    // Write select polarity follows the timing model
    wire ws_asserted = cascade_timing_select ? write_select
                                             : ~write_select;
    wire selected    = ~address_match_n & ws_asserted;

    logic select_q;
    logic select_d;
    assign select_d = selected;

    // Cascade writes land one cycle after the select was seen
    wire write_now = cascade_timing_select ? select_q
                                           : selected;

    // ****************************************
    // FIFO storage and pointers
    // ****************************************
    logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0]   wr_ptr_q;
    logic [PTR_W-1:0]   wr_ptr_d;
    logic [PTR_W-1:0]   rd_ptr_q;
    logic [PTR_W-1:0]   rd_ptr_d;
    logic [CNT_W-1:0]   count_q;
    logic [CNT_W-1:0]   count_d;
    thp_drain_t         state_q;
    thp_drain_t         state_d;

    wire is_full  = (count_q == FULL_LEVEL);
    wire is_empty = (count_q == '0);

    // Full FIFO drops the write; the write pointer does not move
    wire push = fifo_on & write_now & ~is_full;
    // Only the drain machine pops
    wire pop  = fifo_on & (state_q == DR_IDLE) & ~is_empty;

    assign wr_ptr_d = push ? wr_ptr_q + 8'h01 : wr_ptr_q;
    assign rd_ptr_d = pop  ? rd_ptr_q + 8'h01 : rd_ptr_q;

    // Level follows both ports in the same cycle
    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 9'h001;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 9'h001;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    // Flags from the next level so they are never a cycle stale
    wire empty_lvl = (count_d == '0);
    wire full_lvl  = (count_d == FULL_LEVEL);
    wire half_lvl  = (count_d >= HALF_LEVEL);

    // Polarity per timing model; half-full is active low always
    wire empty_flag_d = cascade_timing_select ? empty_lvl
                                              : ~empty_lvl;
    wire full_flag_d  = cascade_timing_select ? full_lvl
                                              : ~full_lvl;
    wire half_n_d     = ~half_lvl;

    // ****************************************
    // Drain machine and output word
    // ****************************************
    logic               char_valid_d;
    logic [ENTRY_W-1:0] char_word_d;

    // Buffered: fetch, then hold until taken; bypass: one word per write
    always_comb
    begin
        state_d      = state_q;
        char_valid_d = char_valid;
        char_word_d  = char_word;
        if (!fifo_on)
        begin
            state_d      = DR_IDLE;
            char_valid_d = write_now;
            if (write_now)
            begin
                char_word_d = mapped_entry;
            end
        end
        else
        begin
            case (state_q)
                DR_IDLE:
                begin
                    char_valid_d = 1'b0;
                    if (pop)
                    begin
                        char_word_d  = mem[rd_ptr_q];
                        char_valid_d = 1'b1;
                        state_d      = DR_HOLD;
                    end
                end
                DR_HOLD:
                begin
                    if (char_ready)
                    begin
                        char_valid_d = 1'b0;
                        state_d      = DR_IDLE;
                    end
                end
                default:
                begin
                    state_d      = DR_IDLE;
                    char_valid_d = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Storage array needs no reset; pointers guard it
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= mapped_entry;
        end
    end

    // Pointers, level and select delay
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            select_q <= 1'b0;
            state_q  <= DR_IDLE;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
            select_q <= select_d;
            state_q  <= state_d;
        end
    end

    // Registered outputs, flags on the single clock in both modes
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            // Reset shows empty asserted and full negated, in pin polarity
            fifo_empty_flag  <= cascade_timing_select;
            fifo_full_flag   <= ~cascade_timing_select;
            fifo_half_full_n <= 1'b1;
            char_valid       <= 1'b0;
            char_word        <= ENTRY_RST;
            bit_rate_x2      <= RATE_X2_LOW;
            fifo_mode        <= 1'b0;
        end
        else
        begin
            fifo_empty_flag  <= empty_flag_d;
            fifo_full_flag   <= full_flag_d;
            fifo_half_full_n <= half_n_d;
            char_valid       <= char_valid_d;
            char_word        <= char_word_d;
            bit_rate_x2      <= rate_d;
            fifo_mode        <= fifo_on;
        end
    end

endmodule : thp_tx_port

// >>> shared/thp_pkg.sv
// Constants and types for the transmit host port with its transmit FIFO.
// Assumes one clock, synchronous active-low reset, static mode pins.
// What this block does
// - With FIFO enabled, host writes a 256-character synchronous FIFO, up to 50 MHz.
// - Bit rate is 2.5, 5 or 10 times clock; 3, 6, 12 in raw 12-bit.
// - Twelve data inputs and special select are captured on the sample edge.
// - Encoded 8-bit: data 0-7, interrupt 8, halt 9, violation 10, cell start 11; bypassed keeps only bits 0-7 and 10.
// - Raw 10-bit: bits 0-9 pass raw; special, violation, cell start ignored.
// - Encoded 10-bit: data 0-9, violation 10, cell start 11 only when buffered.
// - Raw 12-bit: all twelve bits pass unencoded; special select ignored.
// - Bits with no function in the active mode are ignored.
// - In raw modes bit 0 is sent first, then ascending order.
// - Buffer bypass low disables the FIFO; all runs on the reference clock.
// - Buffer bypass high: host clock writes the FIFO, reference clock reads it.
// - Clocking mode comes from range select, speed select and buffer bypass; the rate here follows range, speed and raw 12-bit mode.
// - UTOPIA timing: empty, full and write select are active low.
// - UTOPIA: once addressed and selected, write every cycle write select stays low; here each write also needs address_match_n low.
// - Cascade timing: empty, full, write select active high; same addressing.
// - Cascade: data arrives one cycle after write select is asserted.
// - The transmit FIFO holds 256 entries of 14 bits.
// - Addressed and selected write captures data and command into the FIFO.
// - FIFO gives full, half-full and empty flags on the host clock.
// - A state machine on the reference clock does all FIFO reads.
// - Half-full flag stays active low under cascade timing.
// - With buffers bypassed, flags are synchronous to the reference clock.

package thp_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int FIFO_DEPTH  = 256;
    localparam int PTR_W       = 8;
    localparam int CNT_W       = 9;
    localparam int WORD_W      = 12;
    localparam int ENTRY_W     = 14;
    localparam logic [CNT_W-1:0] HALF_LEVEL = 9'h080;
    localparam logic [CNT_W-1:0] FULL_LEVEL = 9'h100;

    // ****************************************
    // Entry field positions
    // ****************************************
    localparam int F_SCD    = 12;  // Special-or-data select
    localparam int F_RAW    = 13;  // Character was captured uncoded

    // Word masks per character mode, buffered / bypassed
    localparam logic [WORD_W-1:0] MASK_ENC8_BUF  = 12'hFFF;
    localparam logic [WORD_W-1:0] MASK_ENC8_BYP  = 12'h4FF;
    localparam logic [WORD_W-1:0] MASK_RAW10     = 12'h3FF;
    localparam logic [WORD_W-1:0] MASK_ENC10_BUF = 12'hFFF;
    localparam logic [WORD_W-1:0] MASK_ENC10_BYP = 12'h7FF;
    localparam logic [WORD_W-1:0] MASK_RAW12     = 12'hFFF;

    // ****************************************
    // Bit rate as twice the clock multiple
    // ****************************************
    localparam logic [4:0] RATE_X2_LOW  = 5'h05;
    localparam logic [4:0] RATE_X2_MID  = 5'h0A;
    localparam logic [4:0] RATE_X2_HIGH = 5'h14;
    localparam logic [4:0] RATE_X2_LOW12  = 5'h06;
    localparam logic [4:0] RATE_X2_MID12  = 5'h0C;
    localparam logic [4:0] RATE_X2_HIGH12 = 5'h18;

    // Reset values
    localparam logic [ENTRY_W-1:0] ENTRY_RST = 14'h0000;

    // Drain state machine
    typedef enum logic [1:0]
    {
        DR_IDLE = 2'b01,
        DR_HOLD = 2'b10
    } thp_drain_t;

endpackage : thp_pkg

// >>> testbench/thp_tx_port_monitor.sv
// Checker on the ports of the transmit host port, bound to the top.
// Assumes mode pins stay static while reset_n is high.
`timescale 1ns/1ps
module thp_tx_port_monitor
    import thp_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      reset_n,
    input wire logic                      buffer_bypass_select,
    input wire logic                      coder_bypass_select,
    input wire logic                      char_width_select,
    input wire logic                      cascade_timing_select,
    input wire logic                      range_select_pin,
    input wire logic                      speed_select_pin,
    input wire logic                      address_match_n,
    input wire logic                      write_select,
    input wire logic [thp_pkg::WORD_W-1:0] tx_parallel_word,
    input wire logic                      special_or_data_select,
    input wire logic                      char_ready,
    input wire logic                      fifo_empty_flag,
    input wire logic                      fifo_full_flag,
    input wire logic                      fifo_half_full_n,
    input wire logic                      char_valid,
    input wire logic [thp_pkg::ENTRY_W-1:0] char_word,
    input wire logic [4:0]                bit_rate_x2,
    input wire logic                      fifo_mode
);
    // ****************************************
    // Fill level model
    // ****************************************
    logic [CNT_W-1:0] lvl_q;
    logic             sel_q;
    // Cascade takes data one edge after the select was seen
    wire sel  = !address_match_n && (write_select == cascade_timing_select);
    wire take = cascade_timing_select ? sel_q : sel;
    wire push = buffer_bypass_select && take && (lvl_q != FULL_LEVEL);
    wire pop  = buffer_bypass_select && !char_valid && (lvl_q != '0);
    wire raw12 = !coder_bypass_select && !char_width_select;
    wire [4:0] rate_exp = range_select_pin ?
        (raw12 ? RATE_X2_HIGH12 : RATE_X2_HIGH) : speed_select_pin ?
        (raw12 ? RATE_X2_MID12 : RATE_X2_MID) :
        (raw12 ? RATE_X2_LOW12 : RATE_X2_LOW);
    // Push and pop may share an edge, so both land in one update
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            lvl_q <= '0;
            sel_q <= 1'b0;
        end
        else
        begin
            lvl_q <= lvl_q + CNT_W'(push) - CNT_W'(pop);
            sel_q <= sel;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_full_level: assert property (
        fifo_full_flag == ((lvl_q == FULL_LEVEL) ~^ cascade_timing_select))
        else $error("full flag disagrees with level");
    a_empty_level: assert property (
        fifo_empty_flag == ((lvl_q == '0) ~^ cascade_timing_select))
        else $error("empty flag disagrees with level");
    a_half_level: assert property (
        fifo_half_full_n == !(lvl_q >= HALF_LEVEL))
        else $error("half flag disagrees with level");
    a_rate_pins: assert property (
        $past(reset_n) |-> bit_rate_x2 == rate_exp)
        else $error("bit rate does not follow the pins");
    a_bypass_pulse: assert property (
        !buffer_bypass_select |=> char_valid == $past(take))
        else $error("bypass valid is not one pulse per write");
    a_hold_char: assert property (
        buffer_bypass_select && char_valid && !char_ready
        |=> char_valid && $stable(char_word))
        else $error("held character changed while stalled");
    a_valid_gap: assert property (
        buffer_bypass_select && char_valid && char_ready |=> !char_valid)
        else $error("valid stayed high after the take");
    a_prompt_pop: assert property (
        buffer_bypass_select && !char_valid && lvl_q != '0 |=> char_valid)
        else $error("drain missed a waiting character");
    a_raw_plain: assert property (
        char_valid && !coder_bypass_select |-> !char_word[12] && char_word[13])
        else $error("raw character carries a special marker");
endmodule : thp_tx_port_monitor

bind thp_tx_port thp_tx_port_monitor thp_tx_port_monitor_inst (.*);

// >>> testbench/thp_host_model.sv
// Host bus model for the write side of the transmit host port.
// Assumes its tasks are called from the bench between falling edges.
`timescale 1ns/1ps
module thp_host_model
    import thp_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      cascade_timing_select,
    output logic                           address_match_n,
    output logic                           write_select,
    output logic [thp_pkg::WORD_W-1:0]     tx_parallel_word,
    output logic                           special_or_data_select
);
    // Parked bus: deselected, data inverted so a stale word never looks held
    task automatic idle();
        address_match_n = 1'b1;
        write_select = !cascade_timing_select;
        tx_parallel_word = ~tx_parallel_word;
        special_or_data_select = ~special_or_data_select;
    endtask : idle
    // Back-to-back writes; in cascade the data trails the select a cycle
    task automatic burst(input logic [WORD_W-1:0] base, input int n,
                         input logic scd);
        int i;
        int lag;
        lag = cascade_timing_select ? 1 : 0;
        for (i = 0; i < n + lag; i++)
        begin
            @(negedge clock);
            address_match_n = 1'b0;
            write_select = ((i < n) == cascade_timing_select);
            tx_parallel_word = base + WORD_W'(i - lag);
            special_or_data_select = scd;
        end
        @(negedge clock);
        idle();
    endtask : burst
    // Start with a known word so the first inversion is defined
    initial
    begin
        tx_parallel_word = 12'h5A5;
        special_or_data_select = 1'b0;
        idle();
    end
endmodule : thp_host_model

// >>> testbench/thp_tx_port_bench.sv
// Self-checking bench for the transmit host port in its main modes.
// Assumes one clock serves host writes and the FIFO drain alike.
`timescale 1ns/1ps
module thp_tx_port_bench;
    import thp_pkg::*;
    logic               clock = 1'b0;
    logic               reset_n = 1'b0;
    logic               buffer_bypass_select = 1'b1;
    logic               coder_bypass_select = 1'b1;
    logic               char_width_select = 1'b1;
    logic               cascade_timing_select = 1'b0;
    logic               range_select_pin = 1'b0;
    logic               speed_select_pin = 1'b0;
    logic               char_ready = 1'b0;
    logic               address_match_n;
    logic               write_select;
    logic [WORD_W-1:0]  tx_parallel_word;
    logic               special_or_data_select;
    logic               fifo_empty_flag;
    logic               fifo_full_flag;
    logic               fifo_half_full_n;
    logic               char_valid;
    logic [ENTRY_W-1:0] char_word;
    logic [4:0]         bit_rate_x2;
    logic               fifo_mode;
    int                 error_cnt = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    thp_tx_port thp_tx_port_inst (.*);
    thp_host_model thp_host_model_inst (.*);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [ENTRY_W-1:0] act, exp);
        cmp_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, act, exp);
        end
    endtask : chk
    // Pins change only under reset, as they are static straps
    task automatic start(input logic [5:0] m);
        @(negedge clock);
        reset_n = 1'b0;
        char_ready = 1'b0;
        {buffer_bypass_select, coder_bypass_select, char_width_select,
         cascade_timing_select, range_select_pin, speed_select_pin} = m;
        thp_host_model_inst.idle();
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
    endtask : start
    // Accept one held character, bounded wait
    task automatic take_char(input logic [ENTRY_W-1:0] exp);
        int n;
        n = 0;
        char_ready = 1'b1;
        while (char_valid !== 1'b1 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        chk(char_word, exp);
        @(negedge clock);
    endtask : take_char
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        start(6'b111000);
        chk(14'({fifo_full_flag, fifo_half_full_n}), 14'h0003);
        chk(14'({fifo_empty_flag, char_valid, fifo_mode}), 14'h0000);
        chk(char_word, ENTRY_RST);
        chk(14'(bit_rate_x2), 14'h0005);
    endtask : t_reset
    // Overfill with the drain stalled, then drain everything in order
    task automatic t_fill();
        int i;
        start(6'b111000);
        thp_host_model_inst.burst(12'h000, 258, 1'b0);
        chk(14'({fifo_full_flag, fifo_half_full_n, fifo_empty_flag}),
            14'h0001);
        thp_host_model_inst.burst(12'h777, 1, 1'b1);
        for (i = 0; i < 257; i++)
            take_char(14'(i));
        chk(14'(fifo_empty_flag), 14'h0000);
    endtask : t_fill
    task automatic t_cascade();
        start(6'b110100);
        chk(14'({fifo_full_flag, fifo_empty_flag}), 14'h0001);
        thp_host_model_inst.burst(12'hA5C, 2, 1'b1);
        take_char(14'h1A5C);
        take_char(14'h1A5D);
        chk(14'(fifo_empty_flag), 14'h0001);
    endtask : t_cascade
    // Bypass never uses encoded 10-bit, which the host must avoid
    task automatic t_bypass();
        logic [5:0]  mode [3] = '{6'b011000, 6'b001001, 6'b000010};
        logic [13:0] want [3] = '{14'h14FF, 14'h23FF, 14'h2FFF};
        logic [4:0]  rate [3] = '{5'h05, 5'h0A, 5'h18};
        int k;
        for (k = 0; k < 3; k++)
        begin
            start(mode[k]);
            thp_host_model_inst.burst(12'hFFF, 1, 1'b1);
            chk(char_word, want[k]);
            chk(14'(char_valid), 14'h0001);
            @(negedge clock);
            chk(14'({char_valid, fifo_empty_flag}), 14'h0000);
            chk(14'(bit_rate_x2), 14'(rate[k]));
        end
    endtask : t_bypass
    initial
    begin
        forever #4 clock = ~clock;
    end
    // Hang guard; the run needs about 830 cycles
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end
    initial
    begin
        t_reset();
        t_fill();
        t_cascade();
        t_bypass();
        end_of_test();
    end
endmodule : thp_tx_port_bench
